// file: inc/async_serial_receiver_regs.vh
// Purpose: Constants shared by the asynchronous serial receiver and its buffer
// Assumes: Included by bare name after `default_nettype none
// Notes:   Definitions only; the control bits are plain ports, not registers
`ifndef ASYNC_SERIAL_RECEIVER_REGS_VH
`define ASYNC_SERIAL_RECEIVER_REGS_VH

// Fixed divide by four ahead of the programmable divider
`define PRESCALE_LAST   2'h3
`define PRESCALE_STEP   2'h1
`define PRESCALE_FIRST  2'h0

// Tick numbers within one bit period; tick 16 wraps the count to zero
`define EDGE_SAMPLE_1   4'h7
`define EDGE_SAMPLE_2   4'h8
`define EDGE_SAMPLE_3   4'h9
`define EDGE_BIT_END    4'h0
`define EDGE_STEP       4'h1
`define EDGE_FIRST      4'h0

// Character length
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9
`define BIT_FIRST       4'h0
`define BIT_STEP        4'h1

// Line levels
`define LEVEL_IDLE      1'b1
`define LEVEL_STOP      1'b1

// FIFO entry layout
`define ENTRY_WIDTH     10
`define FLD_FRAME_ERR   9
`define FLD_NINTH       8
`define FLD_DATA_MSB    7
`define LAST_WORD_LEVEL 2'h1

// Reset values of the sampler and the shift register
`define SAMPLES_IDLE    2'h3
`define SHIFT_CLEAR     9'h000

`endif

// file: verif/rx_port_checker_asserts.sv
// Purpose: Concurrent checks on the serial receiver's ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees only top-level ports; bound to every receiver instance
`timescale 1ns/1ns
`default_nettype none

module rx_port_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Control
  input wire logic       continuous_receive_enable,
  input wire logic       receive_interrupt_enable,
  // Read side and status
  input wire logic [7:0] rx_data,
  input wire logic       ninth_received_bit,
  input wire logic       framing_error_flag,
  input wire logic       rx_data_valid,
  input wire logic       rx_data_read,
  input wire logic       receive_ready_flag,
  input wire logic       overrun_flag,
  input wire logic       receive_interrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // A read taken by the head, and a head left untouched
  sequence s_pop;
    rx_data_valid && rx_data_read;
  endsequence
  sequence s_idle_head;
    rx_data_valid && !rx_data_read;
  endsequence

  // Interrupt is the flag gated by the enable seen one edge earlier
  AST_IRQ_GATE: assert property (receive_interrupt == (receive_ready_flag && $past(receive_interrupt_enable)))
    else $error("interrupt does not follow gated flag");
  AST_FLAG_TRACKS_FIFO: assert property (receive_ready_flag == rx_data_valid)
    else $error("ready flag differs from fifo occupancy");
  AST_POP_EMPTY: assert property (s_pop ##1 !rx_data_valid |-> !receive_ready_flag && !receive_interrupt)
    else $error("flag left set after fifo emptied");
  AST_HEAD_HOLDS: assert property (s_idle_head |=> rx_data_valid
                                   && $stable({framing_error_flag, ninth_received_bit, rx_data}))
    else $error("head entry changed without a read");
  AST_OVR_CLEARS: assert property (!continuous_receive_enable |=> !overrun_flag)
    else $error("overrun not cleared by receive reset");
  AST_OVR_STICKS: assert property (overrun_flag && continuous_receive_enable |=> overrun_flag)
    else $error("overrun dropped while enabled");
  AST_OVR_ON_FULL: assert property ($rose(overrun_flag) |-> rx_data_valid && $past(rx_data_valid))
    else $error("overrun raised with fifo not full");
  AST_OVR_BLOCKS: assert property (overrun_flag && !rx_data_valid |=> !rx_data_valid)
    else $error("fifo written while overrun set");
  AST_RX_NEEDS_EN: assert property ($rose(rx_data_valid) |-> $past(continuous_receive_enable, 2))
    else $error("character accepted while disabled");
endmodule

bind async_serial_receiver rx_port_checker u_rx_chk (.clk_sys, .reset, .continuous_receive_enable,
  .receive_interrupt_enable, .rx_data, .ninth_received_bit, .framing_error_flag, .rx_data_valid,
  .rx_data_read, .receive_ready_flag, .overrun_flag, .receive_interrupt);

`default_nettype wire

// file: verif/serial_tx_model.sv
// Purpose: Remote asynchronous transmitter driving the receive line
// Assumes: Caller sets bit_clks to match the receiver's divider
// Notes:   Line idles high, as a pulled-up line would when released
`timescale 1ns/1ns
`default_nettype none

module serial_tx_model (
  // Clock and line
  input  wire logic clk_sys,
  output var  logic line
);
  int bit_clks = 64;

  initial line = 1'b1;

  // Start, data LSB first, stop, two idle bits; stop_ok low forges a bad stop
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok);
    int nb;
    nb = nine ? 9 : 8;
    for (int i = 0; i < nb + 4; i++) begin
      @(negedge clk_sys);
      line = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stop_ok : 1'b1;
      repeat (bit_clks - 1) @(negedge clk_sys);
    end
  endtask

  // Short low pulse that a mid-bit vote must reject
  task automatic glitch(input int clks);
    @(negedge clk_sys);
    line = 1'b0;
    repeat (clks) @(negedge clk_sys);
    line = 1'b1;
    repeat (2 * bit_clks) @(negedge clk_sys);
  endtask
endmodule

`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench for the serial receiver
// Assumes: Inputs change at falling edges; design samples on rising edges
// Notes:   Overrun case fills the fifo to refusal, then drains it empty
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
  // Stimulus
  logic       clk_sys                   = 1'b0;
  logic       reset                     = 1'b1;
  logic       continuous_receive_enable = 1'b0;
  logic       receive_interrupt_enable  = 1'b1;
  logic       nine_bit_mode             = 1'b0;
  logic [7:0] baud_divider              = 8'h00;
  logic       rx_data_read              = 1'b0;
  // Observation
  wire logic       serial_line;
  wire logic [7:0] rx_data;
  wire logic       ninth_received_bit;
  wire logic       framing_error_flag;
  wire logic       rx_data_valid;
  wire logic       receive_ready_flag;
  wire logic       overrun_flag;
  wire logic       receive_interrupt;
  int              error_cnt = 0;
  int              cmp_count = 0;

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  async_serial_receiver dut (
    .clk_sys(clk_sys), .reset(reset), .receive_pin(serial_line),
    .continuous_receive_enable(continuous_receive_enable), .receive_interrupt_enable(receive_interrupt_enable),
    .nine_bit_mode(nine_bit_mode), .baud_divider(baud_divider), .rx_data(rx_data),
    .ninth_received_bit(ninth_received_bit), .framing_error_flag(framing_error_flag),
    .rx_data_valid(rx_data_valid), .rx_data_read(rx_data_read), .receive_ready_flag(receive_ready_flag),
    .overrun_flag(overrun_flag), .receive_interrupt(receive_interrupt));

  serial_tx_model line_src (.clk_sys(clk_sys), .line(serial_line));

  // Status before pop, since the pop exposes the next entry's flags
  task automatic rd(input logic [7:0] d, input logic n, input logic f);
    `CHK({rx_data_valid, framing_error_flag, ninth_received_bit}, {1'b1, f, n})
    `CHK(rx_data, d)
    rx_data_read = 1'b1;
    @(negedge clk_sys);
    rx_data_read = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic done(input string s);
    $display("test %s finished, checks so far %0d", s, cmp_count);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the roughly 6600 cycles the tests need
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    `CHK({rx_data_valid, receive_ready_flag, overrun_flag, receive_interrupt}, 4'h0)
    done("reset");
    line_src.send(9'h05A, 1'b0, 1'b1);
    `CHK(rx_data_valid, 1'b0)
    done("disabled");
    continuous_receive_enable = 1'b1;
    line_src.glitch(12);
    `CHK(rx_data_valid, 1'b0)
    line_src.send(9'h0A5, 1'b0, 1'b1);
    `CHK({receive_ready_flag, receive_interrupt}, 2'h3)
    rd(8'hA5, 1'b0, 1'b0);
    `CHK({rx_data_valid, receive_ready_flag, receive_interrupt}, 3'h0)
    done("single");
    // Three characters back to back with no reads
    nine_bit_mode = 1'b1;
    line_src.send(9'h1C3, 1'b1, 1'b0);
    line_src.send(9'h03C, 1'b1, 1'b1);
    `CHK(overrun_flag, 1'b0)
    line_src.send(9'h155, 1'b1, 1'b1);
    `CHK(overrun_flag, 1'b1)
    receive_interrupt_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK({receive_ready_flag, receive_interrupt}, 2'h2)
    rd(8'hC3, 1'b1, 1'b1);
    rd(8'h3C, 1'b0, 1'b0);
    `CHK(rx_data_valid, 1'b0)
    line_src.send(9'h066, 1'b1, 1'b1);
    `CHK(rx_data_valid, 1'b0)
    done("overrun");
    continuous_receive_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(overrun_flag, 1'b0)
    // Restart at half the bit rate with eight data bits
    continuous_receive_enable = 1'b1;
    receive_interrupt_enable = 1'b1;
    nine_bit_mode = 1'b0;
    baud_divider = 8'h01;
    line_src.bit_clks = 128;
    line_src.send(9'h081, 1'b0, 1'b1);
    `CHK({receive_ready_flag, receive_interrupt}, 2'h3)
    rd(8'h81, 1'b0, 1'b0);
    done("recover");
    report_and_stop();
  end
endmodule

`default_nettype wire

// file: verilog/async_serial_receiver.v
// Purpose: Asynchronous serial receiver with x16 recovery and two-deep FIFO
// Assumes: clk_sys at 125 MHz; receive_pin is asynchronous to it
// Notes:   Control and status bits are plain ports; outputs come from flops
//          nine_bit_mode and baud_divider should change only while idle
//          The FIFO survives a dropped enable; only reads or reset empty it
`timescale 1ns/1ns
`default_nettype none
`include "async_serial_receiver_regs.vh"

module async_serial_receiver #(
  parameter DIV_W = 8,
  parameter DEPTH = 2
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // Serial line
  input  wire             receive_pin,
  // Control
  input  wire             continuous_receive_enable,
  input  wire             receive_interrupt_enable,
  input  wire             nine_bit_mode,
  input  wire [DIV_W-1:0] baud_divider,
  // Receive data side
  output wire [7:0]       rx_data,
  output wire             ninth_received_bit,
  output wire             framing_error_flag,
  output wire             rx_data_valid,
  input  wire             rx_data_read,
  // Status and interrupt
  output wire             receive_ready_flag,
  output wire             overrun_flag,
  output wire             receive_interrupt
);

  // One-hot receiver states
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_DATA  = 4'h4;
  localparam [3:0] ST_STOP  = 4'h8;

  // Divider count constants
  localparam [DIV_W-1:0] DIV_ZERO = {DIV_W{1'b0}};
  localparam [DIV_W-1:0] DIV_STEP = 1;

  // Majority of three samples
  function majority3;
    input [2:0] s;
    begin
      majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    end
  endfunction

  // Phase count after the pending tick; sixteen ticks wrap it to zero
  function [3:0] phase_after;
    input [3:0] phase;
    begin
      phase_after = phase + `EDGE_STEP;
    end
  endfunction

  // Ticks seven and eight feed the two stored samples of the vote
  function is_early_sample;
    input [3:0] phase;
    begin
      is_early_sample = (phase == `EDGE_SAMPLE_1) || (phase == `EDGE_SAMPLE_2);
    end
  endfunction

  // One FIFO entry: framing error, ninth bit, then the data byte.
  // Eight-bit characters sit one place higher after the last shift.
  function [`ENTRY_WIDTH-1:0] pack_entry;
    input       bad_stop;
    input       nine;
    input [8:0] shifted;
    begin
      if (nine) begin
        pack_entry = {bad_stop, shifted[8], shifted[7:0]};
      end else begin
        pack_entry = {bad_stop, 1'b0, shifted[8:1]};
      end
    end
  endfunction

  // Pin synchroniser
  reg pin_meta_reg;
  reg pin_sync_reg;

  // Oversampling divider
  reg [1:0]       pre_cnt_reg;
  reg [DIV_W-1:0] div_cnt_reg;
  reg             os_tick_reg;

  // Receive sequencer
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] edge_cnt_reg;
  reg [3:0] edge_cnt_next;
  reg [1:0] samples_reg;
  reg [1:0] samples_next;
  reg [3:0] bit_cnt_reg;
  reg [3:0] bit_cnt_next;
  reg [8:0] receive_shift_register_reg;
  reg [8:0] receive_shift_register_next;
  reg       push_req;
  reg       frame_bad;

  // Flags
  reg overrun_reg;
  reg overrun_next;
  reg ready_flag_reg;
  reg ready_flag_next;
  reg irq_reg;

  // FIFO wiring
  wire [`ENTRY_WIDTH-1:0] fifo_in_data;
  wire [`ENTRY_WIDTH-1:0] fifo_out_data;
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire [1:0]              fifo_level;
  wire                    fifo_push;
  wire                    fifo_pop;

  wire [3:0] edge_after = phase_after(edge_cnt_reg);
  wire       decide_tick;
  wire       bit_end_tick;
  wire       vote;
  wire [3:0] char_bits;

  // Two flops before any logic sees the pin; idle level at reset
  // Only the second flop is read, so a metastable first stage never spreads
  always @(posedge clk_sys) begin
    if (reset) begin
      pin_meta_reg <= `LEVEL_IDLE;
      pin_sync_reg <= `LEVEL_IDLE;
    end else begin
      pin_meta_reg <= receive_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Free-running x16 tick: divide by four, then by divider plus one
  // The count restarts if the divider is lowered below it, so a
  // rate change never waits a full wrap of the counter.
  // At a divider of zero the tick comes on every fourth clock.
  always @(posedge clk_sys) begin
    if (reset) begin
      pre_cnt_reg <= `PRESCALE_FIRST;
      div_cnt_reg <= DIV_ZERO;
      os_tick_reg <= 1'b0;
    end else begin
      os_tick_reg <= 1'b0;
      if (pre_cnt_reg == `PRESCALE_LAST) begin
        pre_cnt_reg <= `PRESCALE_FIRST;
        if (div_cnt_reg >= baud_divider) begin
          div_cnt_reg <= DIV_ZERO;
          os_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + DIV_STEP;
        end
      end else begin
        pre_cnt_reg <= pre_cnt_reg + `PRESCALE_STEP;
      end
    end
  end

  // Frame timing in x16 ticks, counted from the tick after the start edge:
  //   ticks 7 and 8 store samples, tick 9 votes with the live level,
  //   tick 16 wraps the phase count and ends the bit.
  // The stop bit is decided at its tick nine and pushed at once, so a
  // following start edge is caught even when the far end sends no idle.
  // Limitation: the phase restarts only at a start edge, so a far end whose
  // rate is off by more than a few percent drifts out of the sample window.

  // Third sample is the live synchronised level at tick nine
  assign decide_tick  = os_tick_reg && (edge_after == `EDGE_SAMPLE_3);
  assign bit_end_tick = os_tick_reg && (edge_after == `EDGE_BIT_END);
  assign vote         = majority3({samples_reg, pin_sync_reg});
  // The mode is read live; changing it mid-character corrupts that word
  assign char_bits    = nine_bit_mode ? `BITS_NINE : `BITS_EIGHT;

  // Sequencer: start check, data bits, stop bit
  always @* begin
    state_next                  = state_reg;
    edge_cnt_next               = edge_cnt_reg;
    samples_next                = samples_reg;
    bit_cnt_next                = bit_cnt_reg;
    receive_shift_register_next = receive_shift_register_reg;
    push_req                    = 1'b0;
    frame_bad                   = 1'b0;

    // Collect samples on ticks seven and eight of each bit
    if (os_tick_reg && state_reg != ST_IDLE) begin
      edge_cnt_next = edge_after;
      if (is_early_sample(edge_after)) begin
        samples_next = {samples_reg[0], pin_sync_reg};
      end
    end

    case (state_reg)
      ST_IDLE: begin
        // Phase counter held at zero so sampling lines up with the edge
        edge_cnt_next = `EDGE_FIRST;
        bit_cnt_next  = `BIT_FIRST;
        if (continuous_receive_enable && pin_sync_reg != `LEVEL_IDLE) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        // A start bit that votes high was a glitch
        // This also drops the false start that a low stop bit leaves behind
        if (decide_tick && vote == `LEVEL_IDLE) begin
          state_next = ST_IDLE;
        end else if (bit_end_tick) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (decide_tick) begin
          receive_shift_register_next = {vote, receive_shift_register_reg[8:1]};
          bit_cnt_next = bit_cnt_reg + `BIT_STEP;
        end
        // Leave at the sixteenth tick of the last data bit
        if (bit_end_tick && bit_cnt_reg == char_bits) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        // Hand over at the stop decision; the line is idle afterwards
        // A low stop is still stored, with the framing error beside the data
        if (decide_tick) begin
          push_req   = 1'b1;
          frame_bad  = (vote != `LEVEL_STOP);
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    // Dropping the enable resets the receive logic at once
    // The FIFO keeps its words, so software can still drain them afterwards
    if (!continuous_receive_enable) begin
      state_next    = ST_IDLE;
      edge_cnt_next = `EDGE_FIRST;
      bit_cnt_next  = `BIT_FIRST;
      push_req      = 1'b0;
    end
  end

  // Sequencer registers; the FIFO and its flags are held elsewhere so that
  // a dropped enable clears the sequencer without losing stored words.
  // The sampler resets to the idle level so the first vote is not a start.
  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg                  <= ST_IDLE;
      edge_cnt_reg               <= `EDGE_FIRST;
      samples_reg                <= `SAMPLES_IDLE;
      bit_cnt_reg                <= `BIT_FIRST;
      receive_shift_register_reg <= `SHIFT_CLEAR;
    end else begin
      state_reg                  <= state_next;
      edge_cnt_reg               <= edge_cnt_next;
      samples_reg                <= samples_next;
      bit_cnt_reg                <= bit_cnt_next;
      receive_shift_register_reg <= receive_shift_register_next;
    end
  end

  // Entry: framing error, ninth bit and data stored together
  assign fifo_in_data = pack_entry(frame_bad, nine_bit_mode, receive_shift_register_reg);

  // No transfer while overrun stands; full FIFO drops the word
  assign fifo_push = push_req && !overrun_reg && fifo_in_ready;
  assign fifo_pop  = fifo_out_valid && rx_data_read;

  // Two-entry buffer in the data path. A reader that stalls loses nothing
  // until both entries are full and a third stop bit arrives; the level
  // output tells the ready flag when a read empties it.
  receive_data_fifo #(
    .WIDTH (`ENTRY_WIDTH),
    .DEPTH (DEPTH),
    .CW    (2)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (rx_data_read),
    .level     (fifo_level)
  );

  // Overrun: set on a stop bit that finds the FIFO full
  // A new overrun and the clearing enable cannot meet: with the
  // enable low no stop bit is ever decided.
  always @* begin
    overrun_next = overrun_reg;
    if (!continuous_receive_enable) begin
      overrun_next = 1'b0;
    end else if (push_req && !overrun_reg && !fifo_in_ready) begin
      overrun_next = 1'b1;
    end
  end

  // Ready flag: a new word wins over a read that empties the FIFO
  // A push and the last read in one cycle leave one word, so the flag stays.
  always @* begin
    ready_flag_next = ready_flag_reg;
    if (fifo_push) begin
      ready_flag_next = 1'b1;
    end else if (fifo_pop && fifo_level == `LAST_WORD_LEVEL) begin
      ready_flag_next = 1'b0;
    end
  end

  // Flag and interrupt registers. The interrupt is a flop of its own, so
  // the output never glitches while the enable changes; it follows the
  // flag in the same cycle because both load from the same next value.
  always @(posedge clk_sys) begin
    if (reset) begin
      overrun_reg    <= 1'b0;
      ready_flag_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      overrun_reg    <= overrun_next;
      ready_flag_reg <= ready_flag_next;
      irq_reg        <= ready_flag_next && receive_interrupt_enable;
    end
  end

  // Head entry registers drive the data and per-entry status
  // Every output is a flop: the FIFO head, its valid bit or a flag register
  assign rx_data            = fifo_out_data[`FLD_DATA_MSB:0];
  assign ninth_received_bit = fifo_out_data[`FLD_NINTH];
  assign framing_error_flag = fifo_out_data[`FLD_FRAME_ERR];
  assign rx_data_valid      = fifo_out_valid;
  assign receive_ready_flag = ready_flag_reg;
  assign overrun_flag       = overrun_reg;
  assign receive_interrupt  = irq_reg;

endmodule

`default_nettype wire

// file: verilog/receive_data_fifo.v
// Purpose: Two-entry receive buffer with valid and ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes:   Entry zero is the head and is read straight from its register
`timescale 1ns/1ns
`default_nettype none

module receive_data_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 2,
  parameter CW    = 2
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // Filling side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // Draining side
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready,
  // Fill level
  output wire [CW-1:0]    level
);

  localparam [CW-1:0] FULL_COUNT = DEPTH;
  localparam [CW-1:0] ONE_COUNT  = 1;

  reg [WIDTH-1:0] entry_reg [0:DEPTH-1];
  reg [CW-1:0]    count_reg;
  reg [CW-1:0]    count_next;
  reg [CW-1:0]    slot;
  reg             valid_reg;
  integer         i;

  wire push = in_valid && (count_reg != FULL_COUNT);
  wire pop  = valid_reg && out_ready;

  assign in_ready  = (count_reg != FULL_COUNT);
  assign out_valid = valid_reg;
  assign out_data  = entry_reg[0];
  assign level     = count_reg;

  // Next fill level and the slot a new word lands in
  always @* begin
    count_next = count_reg;
    slot       = count_reg;
    if (pop) begin
      slot = count_reg - ONE_COUNT;
    end
    if (push && !pop) begin
      count_next = count_reg + ONE_COUNT;
    end else if (pop && !push) begin
      count_next = count_reg - ONE_COUNT;
    end
  end

  // Shift toward the head on a read, so order is kept without pointers
  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        entry_reg[i] <= {WIDTH{1'b0}};
      end
      count_reg <= {CW{1'b0}};
      valid_reg <= 1'b0;
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (pop && (i + 1 < DEPTH)) begin
          entry_reg[i] <= entry_reg[i + 1];
        end
        if (push && (i[CW-1:0] == slot)) begin
          entry_reg[i] <= in_data;
        end
      end
      count_reg <= count_next;
      valid_reg <= (count_next != {CW{1'b0}});
    end
  end

endmodule

`default_nettype wire
